// ### pcs_cpu_model.sv
// Processor model answering data requests with output words
`timescale 1ns/100ps
`default_nettype none
module pcs_cpu_model (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       en_i,
  input  wire logic       slow_i,
  input  wire logic [4:0] words_i,
  input  wire logic       flag_i,
  input  wire logic [1:0] state_i,
  output var  logic       load_o,
  output var  logic [2:0] cont_o,
  output var  logic [4:0] sent_o
);
  logic [4:0] wait_c;
  initial {load_o, cont_o, sent_o, wait_c} = '0;
  // Prompt or late answer; words_i words with C of 4, then C of 0
  always @(negedge ref_clk_i) begin
    load_o <= 1'h0;
    cont_o <= ~cont_o;  // Idle code never holds its last value
    if (!en_i || !reset_n_i) begin
      sent_o <= 5'h00;
      wait_c <= 5'h00;
    end else if (wait_c == 5'h01) begin
      load_o <= 1'h1;
      cont_o <= (sent_o < words_i) ? 3'h4 : 3'h0;
      sent_o <= sent_o + 5'h01;
      wait_c <= 5'h00;
    end else if (wait_c != 5'h00) begin
      wait_c <= wait_c - 5'h01;
    end else if (flag_i && state_i == 2'h2) begin
      wait_c <= slow_i ? 5'h08 : 5'h01;
    end
  end
endmodule : pcs_cpu_model
`default_nettype wire

// ### pcs_defines.svh
// Constants for the peripheral command sequencer
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define PCS_FN_ADV_REC    6'h00
`define PCS_FN_BSP_REC    6'h01
`define PCS_FN_ADV_FILE   6'h02
`define PCS_FN_BSP_FILE   6'h29
`define PCS_FN_REWIND     6'h10
`define PCS_FN_ADV_PRINT  6'h03
`define PCS_FN_ADV_ONLY   6'h01
`define PCS_FN_PRINT_ONLY 6'h02
`define PCS_CONT_MORE     3'h4
`define PCS_ST_ERR_BIT    0
`define PCS_ST_DATA_BIT   25
`define PCS_ST_TIME_BIT   26
`define PCS_ST_SOM_BIT    27
`define PCS_ST_EOM_BIT    28
`define PCS_ST_EOF_BIT    29
`define PCS_LINE_COLS     120
`define PCS_CHARS_WORD    5
`endif

// ### pcs_line_count.sv
// Received-character counter for one print line
`timescale 1ns/100ps
`default_nettype none
`include "pcs_defines.svh"
module pcs_line_count #(
  parameter int COLS = `PCS_LINE_COLS
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic clear_i,
  input  wire logic word_i,
  input  wire logic last_i,
  output logic      full_o
);
  logic [7:0] count;
  logic [8:0] sum;

  assign sum = {1'b0, count} + 9'(`PCS_CHARS_WORD);

  // Counter cleared at each new line
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count  <= 8'h00;
      full_o <= 1'b0;
    end else if (clear_i) begin
      count  <= 8'h00;
      full_o <= 1'b0;
    end else if (word_i && !full_o) begin
      count <= sum[7:0];
      // Short code blanks the rest of the line
      if (last_i || sum >= 9'(COLS)) begin
        full_o <= 1'b1;
      end
    end
  end
endmodule : pcs_line_count
`default_nettype wire

// ### pcs_pkg.sv
// Types for the peripheral command sequencer
package pcs_pkg;
  typedef enum logic [1:0] {
    PCS_AVAIL,
    PCS_CLAIMED,
    PCS_BUSY
  } pcs_cu_state_e;

  typedef enum logic [3:0] {
    PCS_OP_NONE,
    PCS_OP_ADV_REC,
    PCS_OP_BSP_REC,
    PCS_OP_ADV_FILE,
    PCS_OP_BSP_FILE,
    PCS_OP_REWIND,
    PCS_OP_ADV_PRINT,
    PCS_OP_ADV_ONLY,
    PCS_OP_PRINT_ONLY
  } pcs_op_e;
endpackage : pcs_pkg

// ### pcs_sequencer.sv
// Command sequencer for tape positioning and line printer control
// Function
// - Accept tape and printer commands only in the claimed state.
// - Acknowledge accepted command and go busy on the same edge.
// - Advance record: forward to end of record, then complete.
// - Backspace record: reverse to end of record or load point.
// - Advance file: stop at end of file, or gap past warning point.
// - Code 51 backspace file: reverse to end of file or load point.
// - Code 20 rewind: available plus call-back at start, again at end.
// - Store-input or load-output acknowledged after completion; store returns status.
// - Code 03 advance and print: flag on accept and per word wanted.
// - Continuation code 4 or more means more data; below 4 fills line.
// - Line full when received characters reach print positions.
// - Full line stops data requests and flags until printed.
// - Paper advances to next hole in channel given by unit field.
// - Print after advance done and line full, then complete.
// - Code 01 advance only: move paper, complete, request no data.
// - Code 02 print only: collect line, print, complete without advance.
// - Printer end-of-file status means paper on last printable line.
// - Rejected command leaves device alone and gives no acknowledge.
// - Inoperable device: accepted command sets flag at once.
// - Status error bit 0, detail bits 25-29 zeroed when inoperable.
`timescale 1ns/100ps
`default_nettype none
`include "pcs_defines.svh"
module pcs_sequencer
  import pcs_pkg::*;
#(
  parameter int LINE_COLS = `PCS_LINE_COLS
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        claim_i,        // Claim from generic logic
  input  wire logic        release_i,      // Release from generic logic
  input  wire logic        cmd_valid_i,    // Command word strobe
  input  wire logic [5:0]  cmd_func_i,     // Function code field
  input  wire logic        cmd_printer_i,  // Selected device is a printer
  input  wire logic [2:0]  cmd_unit_i,     // Unit field
  input  wire logic        store_input_instr_i,
  input  wire logic        load_output_instr_i,
  input  wire logic [2:0]  load_cont_i,    // Continuation code C
  input  wire logic        end_of_record_i, // Device pins below
  input  wire logic        end_of_file_i,
  input  wire logic        load_point_i,
  input  wire logic        tape_warning_i,
  input  wire logic        rewind_started_i,
  input  wire logic        format_hole_i,
  input  wire logic        bottom_of_form_i,
  input  wire logic        print_done_i,
  input  wire logic        inoperable_i,
  input  wire logic        data_error_i,
  input  wire logic        timing_error_i,
  output logic             service_acknowledge_o,
  output logic             cmd_rejected_o,
  output logic             priority_flag_o,
  output logic             call_back_o,
  output logic [1:0]       cu_state_o,
  output logic [29:0]      status_word_o,
  output logic             tape_forward_o,
  output logic             tape_reverse_o,
  output logic             tape_rewind_o,
  output logic             paper_advance_o,
  output logic             print_strobe_o,
  output logic [2:0]       format_channel_o
);
  logic [8:0]    pins;
  logic          eor, eof, lp, warn, rw_start, hole, bof, pdone, inop;
  pcs_cu_state_e state;
  pcs_op_e       op;
  pcs_op_e       next_op;
  logic          accept;
  logic          adv_done;
  logic          printed;
  logic          line_full;
  logic          want_word;
  logic          rewinding;
  logic          tape_stop;
  logic          paper_stop;
  logic          print_go;
  logic          complete;
  logic          word_more;

  // Device pins are asynchronous, so synchronise first
  pcs_sync #(
    .WIDTH (9)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({end_of_record_i, end_of_file_i, load_point_i,
                 tape_warning_i, rewind_started_i, format_hole_i,
                 bottom_of_form_i, print_done_i, inoperable_i}),
    .sync_o    (pins)
  );
  assign {eor, eof, lp, warn, rw_start, hole, bof, pdone, inop} = pins;

  // Decode function code by device kind
  always_comb begin
    next_op = PCS_OP_NONE;
    if (cmd_printer_i) begin
      case (cmd_func_i)
        `PCS_FN_ADV_PRINT:  next_op = PCS_OP_ADV_PRINT;
        `PCS_FN_ADV_ONLY:   next_op = PCS_OP_ADV_ONLY;
        `PCS_FN_PRINT_ONLY: next_op = PCS_OP_PRINT_ONLY;
        default:            next_op = PCS_OP_NONE;
      endcase
    end else begin
      case (cmd_func_i)
        `PCS_FN_ADV_REC:  next_op = PCS_OP_ADV_REC;
        `PCS_FN_BSP_REC:  next_op = PCS_OP_BSP_REC;
        `PCS_FN_ADV_FILE: next_op = PCS_OP_ADV_FILE;
        `PCS_FN_BSP_FILE: next_op = PCS_OP_BSP_FILE;
        `PCS_FN_REWIND:   next_op = PCS_OP_REWIND;
        default:          next_op = PCS_OP_NONE;
      endcase
    end
  end

  // Only a claimed unit takes a known command
  assign accept = cmd_valid_i && state == PCS_CLAIMED
                  && next_op != PCS_OP_NONE;

  // Tape stop conditions per operation
  always_comb begin
    case (op)
      PCS_OP_ADV_REC:  tape_stop = eor;
      PCS_OP_BSP_REC:  tape_stop = eor || lp;
      PCS_OP_ADV_FILE: tape_stop = eof || (warn && eor);
      PCS_OP_BSP_FILE: tape_stop = eof || lp;
      default:         tape_stop = 1'b0;
    endcase
  end

  // Paper stops on a hole in the held channel
  assign paper_stop = paper_advance_o && hole;
  assign print_go   = !print_strobe_o && !printed && line_full
                      && (op == PCS_OP_PRINT_ONLY
                          || (op == PCS_OP_ADV_PRINT && adv_done));
  assign complete   = state == PCS_BUSY && !inop
                      && (tape_stop
                          || (op == PCS_OP_ADV_ONLY && paper_stop)
                          || (printed && print_strobe_o && pdone)
                          || (op == PCS_OP_REWIND && rw_start));
  assign want_word  = state == PCS_BUSY && !line_full
                      && (op == PCS_OP_ADV_PRINT
                          || op == PCS_OP_PRINT_ONLY);

  pcs_line_count #(
    .COLS (LINE_COLS)
  ) u_line (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (accept),
    .word_i    (want_word && load_output_instr_i),
    .last_i    (load_cont_i < `PCS_CONT_MORE),
    .full_o    (line_full)
  );

  // Control unit state and operation
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= PCS_AVAIL;
      op    <= PCS_OP_NONE;
    end else if (accept) begin
      state <= PCS_BUSY;
      op    <= next_op;
    end else if (state == PCS_BUSY && inop) begin
      state <= PCS_CLAIMED;
      op    <= PCS_OP_NONE;
    end else if (complete) begin
      // Rewind goes available while tape keeps spinning
      state <= (op == PCS_OP_REWIND) ? PCS_AVAIL : PCS_CLAIMED;
      op    <= PCS_OP_NONE;
    end else if (claim_i && state == PCS_AVAIL) begin
      state <= PCS_CLAIMED;
    end else if (release_i && state == PCS_CLAIMED) begin
      state <= PCS_AVAIL;
    end
  end

  // Rewind tracked past the busy period for the second call-back
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rewinding <= 1'b0;
    end else if (accept && next_op == PCS_OP_REWIND && !inop) begin
      rewinding <= 1'b1;
    end else if (rewinding && lp && !tape_rewind_o) begin
      rewinding <= 1'b0;
    end
  end

  // Motion drives to the transport and printer
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tape_forward_o   <= 1'b0;
      tape_reverse_o   <= 1'b0;
      tape_rewind_o    <= 1'b0;
      paper_advance_o  <= 1'b0;
      format_channel_o <= 3'h0;
    end else begin
      if (accept && !inop) begin
        tape_forward_o  <= next_op == PCS_OP_ADV_REC
                           || next_op == PCS_OP_ADV_FILE;
        tape_reverse_o  <= next_op == PCS_OP_BSP_REC
                           || next_op == PCS_OP_BSP_FILE;
        tape_rewind_o   <= next_op == PCS_OP_REWIND;
        paper_advance_o <= next_op == PCS_OP_ADV_PRINT
                           || next_op == PCS_OP_ADV_ONLY;
        if (cmd_printer_i) begin
          format_channel_o <= cmd_unit_i;
        end
      end else begin
        if (tape_stop || inop) begin
          tape_forward_o <= 1'b0;
          tape_reverse_o <= 1'b0;
        end
        // Load point ends rewind motion
        if (lp || inop) begin
          tape_rewind_o <= 1'b0;
        end
        if (paper_stop || inop) begin
          paper_advance_o <= 1'b0;
        end
      end
    end
  end

  // Advance-done and print progress
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      adv_done       <= 1'b0;
      printed        <= 1'b0;
      print_strobe_o <= 1'b0;
    end else if (accept) begin
      adv_done       <= 1'b0;
      printed        <= 1'b0;
      print_strobe_o <= 1'b0;
    end else begin
      if (paper_stop) begin
        adv_done <= 1'b1;
      end
      if (print_go) begin
        print_strobe_o <= 1'b1;
        printed        <= 1'b1;
      end else if (print_strobe_o && pdone) begin
        print_strobe_o <= 1'b0;
      end
    end
  end

  // Word with more to come; flag waits a cycle to see if it filled the line
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_more <= 1'b0;
    end else begin
      word_more <= want_word && load_output_instr_i
                   && load_cont_i >= `PCS_CONT_MORE;
    end
  end

  // Flag, call-back, acknowledge and reject pulses
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      service_acknowledge_o <= 1'b0;
      cmd_rejected_o        <= 1'b0;
      priority_flag_o       <= 1'b0;
      call_back_o           <= 1'b0;
    end else begin
      service_acknowledge_o <= accept
        || (state != PCS_BUSY
            && (store_input_instr_i || load_output_instr_i))
        || (want_word && load_output_instr_i);
      cmd_rejected_o <= cmd_valid_i && !accept;
      // Flag pulses; a full line suppresses data requests
      priority_flag_o <= (accept && (inop
                            || next_op == PCS_OP_ADV_PRINT
                            || next_op == PCS_OP_PRINT_ONLY))
        || (word_more && !line_full && state == PCS_BUSY)
        || (complete && op != PCS_OP_REWIND);
      call_back_o <= complete
        || (rewinding && lp && !tape_rewind_o)
        || (release_i && state == PCS_CLAIMED);
    end
  end

  // Status word; printer end of file is bottom of form
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_word_o <= 30'h00000000;
    end else begin
      status_word_o <= 30'h00000000;
      status_word_o[`PCS_ST_ERR_BIT] <= data_error_i || timing_error_i
                                        || inop;
      if (!inop) begin
        status_word_o[`PCS_ST_DATA_BIT] <= data_error_i;
        status_word_o[`PCS_ST_TIME_BIT] <= timing_error_i;
        status_word_o[`PCS_ST_SOM_BIT]  <= lp;
        status_word_o[`PCS_ST_EOM_BIT]  <= warn;
        status_word_o[`PCS_ST_EOF_BIT]  <= cmd_printer_i ? bof
                                                         : eof;
      end
    end
  end

  assign cu_state_o = state;
endmodule : pcs_sequencer
`default_nettype wire

// ### pcs_sequencer_chk.sv
// Port checker for the command sequencer
`timescale 1ns/100ps
`default_nettype none
module pcs_sequencer_chk (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        cmd_valid_i,
  input wire logic [5:0]  cmd_func_i,
  input wire logic        cmd_printer_i,
  input wire logic [2:0]  cmd_unit_i,
  input wire logic        rewind_started_i,
  input wire logic        inoperable_i,
  input wire logic        service_acknowledge_o,
  input wire logic        cmd_rejected_o,
  input wire logic        priority_flag_o,
  input wire logic        call_back_o,
  input wire logic [1:0]  cu_state_o,
  input wire logic [29:0] status_word_o,
  input wire logic        tape_forward_o,
  input wire logic        tape_rewind_o,
  input wire logic        paper_advance_o,
  input wire logic        print_strobe_o,
  input wire logic [2:0]  format_channel_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // Command taken in the claimed state
  sequence s_take(p, f);
    cmd_valid_i && cu_state_o == 2'h1 && cmd_printer_i == p
      && cmd_func_i == f;
  endsequence
  // Synchronised inoperable level lags the pin by two edges
  a_ack_busy_fwd:
    assert property (s_take(1'h0, 6'h00) ##0 !$past(inoperable_i, 2)
      |=> service_acknowledge_o && cu_state_o == 2'h2 && tape_forward_o)
    else $error("advance record not taken into busy");
  a_reject_idle:
    assert property (cmd_valid_i && cu_state_o != 2'h1
      |=> cmd_rejected_o && !service_acknowledge_o)
    else $error("command outside claimed not refused");
  // Inoperable exit may skip the call-back, so it is left out
  a_done_flags:
    assert property ($past(cu_state_o) == 2'h2 && cu_state_o == 2'h1
      && !inoperable_i |-> call_back_o && priority_flag_o)
    else $error("completion without call-back and flag");
  a_rewind_avail:
    assert property (cu_state_o == 2'h2 && tape_rewind_o && rewind_started_i
      |-> ##[1:4] (cu_state_o == 2'h0 && call_back_o))
    else $error("rewind start did not free the unit");
  a_print_after:
    assert property ($rose(print_strobe_o)
      |-> !paper_advance_o && cu_state_o == 2'h2)
    else $error("line printed before paper stopped");
  a_adv_channel:
    assert property (s_take(1'h1, 6'h01) ##0 !$past(inoperable_i, 2)
      |=> paper_advance_o && format_channel_o == $past(cmd_unit_i))
    else $error("paper advance or channel wrong");
  a_print_only:
    assert property (s_take(1'h1, 6'h02)
      |=> !paper_advance_o && priority_flag_o)
    else $error("print only advanced or gave no flag");
  // Status seen now was built from the pin three edges back
  a_status_inop:
    assert property ($past(inoperable_i, 3)
      |-> status_word_o[29:25] == 5'h00 && status_word_o[0])
    else $error("detail status not cleared when inoperable");
endmodule : pcs_sequencer_chk
bind pcs_sequencer pcs_sequencer_chk u_pcs_sequencer_chk (.*);
`default_nettype wire

// ### pcs_sync.sv
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/100ps
`default_nettype none
module pcs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : pcs_sync
`default_nettype wire

// ### tb.sv
// Self-checking bench for the command sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        ref_clk_i = '0, reset_n_i = '0, claim_i = '0, release_i = '0;
  logic        cmd_valid_i = '0, cmd_printer_i = '0, store_input_instr_i = '0;
  logic        data_error_i = '0, timing_error_i = '0, load_output_instr_i;
  logic        end_of_record_i, end_of_file_i, load_point_i, tape_warning_i;
  logic        rewind_started_i, format_hole_i, bottom_of_form_i;
  logic        print_done_i, inoperable_i, print_strobe_o, call_back_o;
  logic        service_acknowledge_o, cmd_rejected_o, priority_flag_o;
  logic        tape_forward_o, tape_reverse_o, tape_rewind_o;
  logic        paper_advance_o, cpu_en = '0, cpu_slow = '0;
  logic [1:0]  cu_state_o;
  logic [2:0]  cmd_unit_i = '0, load_cont_i, format_channel_o;
  logic [4:0]  cpu_words = '0, cpu_sent;
  logic [5:0]  cmd_func_i = '0;
  logic [8:0]  pins = '0;
  logic [29:0] status_word_o;
  int          n_fail = 0, tests_run = 0, i;
  // Rows: printer, code, stop pins, expected motion
  logic [19:0] rows [8] = '{
    {1'h0, 6'h00, 9'h001, 4'h1},
    {1'h0, 6'h01, 9'h001, 4'h2},
    {1'h0, 6'h01, 9'h004, 4'h2},
    {1'h0, 6'h02, 9'h002, 4'h1},
    {1'h0, 6'h02, 9'h009, 4'h1},
    {1'h0, 6'h29, 9'h002, 4'h2},
    {1'h0, 6'h29, 9'h004, 4'h2},
    {1'h1, 6'h01, 9'h020, 4'h8}};
  wire  [3:0]  mot = {paper_advance_o, tape_rewind_o, tape_reverse_o,
                      tape_forward_o};
  wire  [4:0]  watch = {cpu_sent == 5'h04, cu_state_o == 2'h1,
                        priority_flag_o, print_strobe_o, call_back_o};
  // Device pins from one vector, end of record at bit 0
  assign {inoperable_i, print_done_i, bottom_of_form_i, format_hole_i,
          rewind_started_i, tape_warning_i, load_point_i, end_of_file_i,
          end_of_record_i} = pins;
  // Short line so that four words fill it
  pcs_sequencer #(.LINE_COLS(20)) u_pcs_sequencer (.*);
  pcs_cpu_model u_pcs_cpu_model (.ref_clk_i, .reset_n_i, .en_i(cpu_en),
    .slow_i(cpu_slow), .words_i(cpu_words), .flag_i(priority_flag_o),
    .state_i(cu_state_o), .load_o(load_output_instr_i),
    .cont_o(load_cont_i), .sent_o(cpu_sent));
  always #12.5 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Inputs move at the falling edge, one-cycle strobes
  task automatic cmd(input logic p, input logic [5:0] f, input logic [2:0] u);
    @(negedge ref_clk_i);
    {cmd_valid_i, cmd_printer_i, cmd_func_i, cmd_unit_i} = {1'h1, p, f, u};
    @(negedge ref_clk_i);
    cmd_valid_i = 1'h0;
  endtask : cmd
  // Store (0), claim (1) or release (2)
  task automatic strobe(input int s);
    @(negedge ref_clk_i);
    {release_i, claim_i, store_input_instr_i} = 3'h1 << s;
    @(negedge ref_clk_i);
    {release_i, claim_i, store_input_instr_i} = 3'h0;
  endtask : strobe
  // Bounded wait on one watched event; a hang ends the run
  task automatic waitw(input int b);
    int k;
    for (k = 0; k < 99; k++) begin
      @(negedge ref_clk_i);
      if (watch[b] === 1'h1) break;
    end
    if (k == 99) begin
      n_fail++;
      results();
    end
  endtask : waitw
  task automatic results();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (3) @(negedge ref_clk_i);
    reset_n_i = 1'h1;
    strobe(1);
    strobe(2);
    cmd(1'h0, 6'h00, 3'h0);
    chk({cmd_rejected_o, service_acknowledge_o, mot}, 6'h20);
    strobe(1);
    for (i = 0; i < 8; i++) begin
      cmd(rows[i][19], rows[i][18:13], 3'h5);
      chk({service_acknowledge_o, cu_state_o}, 3'h6);
      chk(mot, rows[i][3:0]);
      pins = rows[i][12:4];
      waitw(0);
      chk({priority_flag_o, cu_state_o}, 3'h5);
      pins = '0;
      strobe(0);
      chk(service_acknowledge_o, 1'h1);
      $display("row %0d done", i);
    end
    cmd(1'h1, 6'h29, 3'h0);
    chk(cmd_rejected_o, 1'h1);
    // Rewind frees the unit at start, calls back again at load point
    cmd(1'h0, 6'h10, 3'h0);
    chk(tape_rewind_o, 1'h1);
    pins = 9'h010;
    waitw(0);
    chk(cu_state_o, 2'h0);
    pins = 9'h004;
    waitw(0);
    chk(cu_state_o, 2'h0);
    $display("rewind done");
    // Inoperable: flag at once, detail status cleared despite data error
    strobe(1);
    pins = 9'h104;
    data_error_i = 1'h1;
    repeat (3) @(negedge ref_clk_i);
    cmd(1'h0, 6'h00, 3'h0);
    chk({service_acknowledge_o, priority_flag_o}, 2'h3);
    waitw(3);
    strobe(0);
    chk({status_word_o[29:25], status_word_o[0]}, 6'h01);
    pins = '0;
    // Device back: the data error detail bit shows again
    repeat (4) @(negedge ref_clk_i);
    chk({status_word_o[29:25], status_word_o[0]}, 6'h03);
    data_error_i = 1'h0;
    $display("inoperable done");
    // Slow processor; four words fill the line, then no more requests
    {cpu_en, cpu_slow, cpu_words} = 7'h7f;
    cmd(1'h1, 6'h03, 3'h6);
    chk({priority_flag_o, paper_advance_o}, 2'h3);
    chk(format_channel_o, 3'h6);
    waitw(4);
    repeat (30) @(negedge ref_clk_i);
    chk({cpu_sent, print_strobe_o}, 6'h08);
    pins = 9'h020;
    waitw(1);
    chk(format_channel_o, 3'h6);
    pins = 9'h080;
    waitw(0);
    chk(cu_state_o, 2'h1);
    $display("advance and print done");
    // Print only: C of 0 on the second word ends the line early
    cpu_en = 1'h0;
    @(negedge ref_clk_i);
    {cpu_en, cpu_slow, cpu_words} = 7'h41;
    pins = 9'h040;
    cmd(1'h1, 6'h02, 3'h0);
    chk(paper_advance_o, 1'h0);
    waitw(1);
    chk(cpu_sent, 5'h02);
    pins = 9'h0c0;
    waitw(0);
    strobe(0);
    chk(status_word_o[29], 1'h1);
    $display("print only done");
    results();
  end
endmodule : tb
`default_nettype wire
